//--- fas_ctrl.sv
// flash access controller: command register, download modes, security
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`include "fas_params.svh"
module fas_ctrl
(
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst_b,
   // register port
   input  wire logic [2:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output wire logic [7:0]            reg_rdata,
   // core code reads and start-up
   input  wire logic                  cpu_cread,
   input  wire logic [15:0]           cpu_caddr,
   input  wire logic                  cpu_ext_exec,
   output wire logic                  code_int,
   output wire logic                  code_deny,
   output wire logic [15:0]           reset_vector,
   output wire logic                  core_hold,
   // serial download
   input  wire logic                  download_strap_pin,
   output wire logic                  sdl_mode,
   input  wire logic                  sdl_req,
   input  wire logic [1:0]            sdl_op,
   input  wire logic [15:0]           sdl_addr,
   input  wire logic [7:0]            sdl_data,
   output wire logic                  sdl_ack,
   output wire logic [7:0]            sdl_rdata,
   // parallel programming pins
   input  wire logic                  pp_mode,
   input  wire logic                  pp_strobe,
   input  wire logic [1:0]            pp_cfg,
   input  wire logic [15:0]           pp_addr,
   input  wire logic [7:0]            pp_d_i,
   output wire logic [7:0]            pp_d_o,
   output wire logic                  pp_d_oe,
   // flash array macro
   input  wire fas_pkg::fas_sec_t     nv_sec,
   output wire fas_pkg::fas_fm_req_t  fm,
   input  wire logic                  fm_done,
   input  wire logic [31:0]           fm_rdata
);
   import fas_pkg::*;

   fas_st_t     st_q;
   fas_st_t     st_d;
   fas_fm_req_t rq;
   logic [4:0]  pin_s;
   logic [7:0]  rbyte;
   logic [15:0] code_a;
   logic [15:0] page_a;
   logic [15:0] byte_a;
   logic        pp_on;
   logic        pp_edge;
   logic        dat_blk;
   logic        ok;

   // mode, strobe, operation and strap pins go through the filter; programmer address and data do not
   fas_sync3 u_sync
   (
      .mclk  (mclk),
      .rst_b (rst_b),
      .pin_a ({pp_cfg, pp_strobe, pp_mode, download_strap_pin}),
      .pin_s (pin_s)
   );

   always_comb
   begin
      st_d    = st_q;
      rq      = '0;
      ok      = 1'b0;
      rbyte   = fm_rdata[{st_q.fm.addr[1:0], 3'b000} +: 8];
      code_a  = {st_q.adrh, st_q.adrl};
      page_a  = {4'h0, st_q.adrh[1:0], st_q.adrl, 2'b00};
      byte_a  = {4'h0, st_q.adrh[3:0], st_q.adrl};
      pp_on   = pin_s[1];
      pp_edge = pin_s[2] & ~st_q.strobe;
      // data array closed to code running from outside while secure is set
      dat_blk = st_q.sec.secure & cpu_ext_exec;

      st_d.strobe   = pin_s[2];
      st_d.fm.req   = 1'b0;
      st_d.sdl_ack  = 1'b0;
      st_d.rdata    = 8'h00;

      // core code reads: decode and security gate
      st_d.code_int  = cpu_caddr < `FAS_CODE_TOP;
      st_d.code_deny = cpu_cread & cpu_ext_exec & st_q.sec.secure
                       & (cpu_caddr < `FAS_CODE_TOP);

      // release the data bus as soon as the programmer stops reading
      if (!pp_on || pin_s[4:3] != `FAS_OP_READ || pp_edge)
      begin
         st_d.pp_oe = 1'b0;
      end

      if (reg_rd)
      begin
         unique case (reg_addr)
            `FAS_OFS_CMD:   st_d.rdata = st_q.cmd;
            `FAS_OFS_BYTE1: st_d.rdata = st_q.page[0];
            `FAS_OFS_BYTE2: st_d.rdata = st_q.page[1];
            `FAS_OFS_BYTE3: st_d.rdata = st_q.page[2];
            `FAS_OFS_BYTE4: st_d.rdata = st_q.page[3];
            `FAS_OFS_ADRL:  st_d.rdata = st_q.adrl;
            `FAS_OFS_ADRH:  st_d.rdata = st_q.adrh;
            `FAS_OFS_STAT:  st_d.rdata = {st_q.state == FAS_S_BUSY, st_q.sec.boot,
                                          st_q.sec.safe, st_q.sec.secure, st_q.sec.lock,
                                          st_q.sdl_mode, st_q.user_download_mode, 1'b0};
         endcase
      end

      // data and address registers; a completing read may overwrite the data bytes
      if (reg_wr)
      begin
         unique case (reg_addr)
            `FAS_OFS_BYTE1: st_d.page[0] = reg_wdata;
            `FAS_OFS_BYTE2: st_d.page[1] = reg_wdata;
            `FAS_OFS_BYTE3: st_d.page[2] = reg_wdata;
            `FAS_OFS_BYTE4: st_d.page[3] = reg_wdata;
            `FAS_OFS_ADRL:  st_d.adrl    = reg_wdata;
            `FAS_OFS_ADRH:  st_d.adrh    = reg_wdata;
            `FAS_OFS_CMD,
            `FAS_OFS_STAT:  ;
         endcase
      end

      unique case (st_q.state)
         FAS_S_INIT:
         begin
            // wait for the strap filter to settle, then take the straps
            st_d.init_cnt = st_q.init_cnt + 2'd1;
            if (st_q.init_cnt == `FAS_INIT_CYC)
            begin
               st_d.state    = FAS_S_IDLE;
               st_d.hold     = 1'b0;
               st_d.sec      = nv_sec;
               st_d.sdl_mode = ~pin_s[0] & ~nv_sec.safe;
               st_d.vec      = nv_sec.boot ? `FAS_BOOT_VEC : `FAS_RST_VEC;
            end
         end

         FAS_S_IDLE:
         begin
            if (reg_wr && reg_addr == `FAS_OFS_CMD)
            begin
               rq.code = st_q.user_download_mode;
               st_d.src = FAS_SRC_CORE;
               // unlisted codes and refused commands leave everything alone
               case (reg_wdata)
                  `FAS_CMD_RDPAGE, `FAS_CMD_VERIFY:
                  begin
                     // code array is read by instruction fetch, not here
                     ok      = ~st_q.user_download_mode & ~dat_blk;
                     rq.op   = FAS_FM_READ;
                     rq.addr = page_a;
                  end
                  `FAS_CMD_RDBYTE:
                  begin
                     ok      = ~st_q.user_download_mode & ~dat_blk;
                     rq.op   = FAS_FM_READ;
                     rq.addr = byte_a;
                  end
                  `FAS_CMD_WRPAGE:
                  begin
                     if (st_q.user_download_mode)
                     begin
                        // whole 256-byte block from XRAM, user region only
                        ok      = code_a < `FAS_USER_TOP;
                        rq.op   = FAS_FM_WRITE256;
                        rq.addr = {st_q.adrh, 8'h00};
                     end
                     else
                     begin
                        ok       = ~dat_blk;
                        rq.op    = FAS_FM_WRITE;
                        rq.addr  = page_a;
                        rq.ben   = 4'hf;
                        rq.wdata = st_q.page;
                     end
                  end
                  `FAS_CMD_WRBYTE:
                  begin
                     ok       = st_q.user_download_mode ? (code_a < `FAS_USER_TOP) : ~dat_blk;
                     rq.op    = FAS_FM_WRITE;
                     rq.addr  = st_q.user_download_mode ? code_a : byte_a;
                     rq.ben   = 4'b0001 << rq.addr[1:0];
                     rq.wdata = {4{st_q.page[0]}};
                  end
                  `FAS_CMD_ERPAGE:
                  begin
                     // a code page is 64 bytes, a data page four
                     ok      = st_q.user_download_mode ? (code_a < `FAS_USER_TOP) : ~dat_blk;
                     rq.op   = FAS_FM_ERASE;
                     rq.addr = st_q.user_download_mode ? {st_q.adrh, st_q.adrl[7:6], 6'h00} : page_a;
                  end
                  `FAS_CMD_ERALL:
                  begin
                     // erase covers everything below addr
                     ok      = st_q.user_download_mode | ~dat_blk;
                     rq.op   = FAS_FM_ARRAY_ERASE_CMD;
                     rq.addr = st_q.user_download_mode ? `FAS_USER_TOP : `FAS_DATA_TOP;
                  end
                  `FAS_CMD_TODATA:
                  begin
                     st_d.user_download_mode = 1'b0;
                     st_d.cmd   = reg_wdata;
                  end
                  `FAS_CMD_TOCODE:
                  begin
                     st_d.user_download_mode = 1'b1;
                     st_d.cmd   = reg_wdata;
                  end
                  default: ;
               endcase
               if (ok)
               begin
                  st_d.cmd = reg_wdata;
               end
            end
            else if (st_q.sdl_mode && sdl_req)
            begin
               // serial loader reaches the whole code array
               rq.code  = 1'b1;
               rq.addr  = sdl_addr;
               st_d.src = FAS_SRC_SDL;
               unique case (sdl_op)
                  `FAS_OP_READ:
                  begin
                     ok    = 1'b1;
                     rq.op = FAS_FM_READ;
                  end
                  `FAS_OP_PROG:
                  begin
                     ok       = sdl_addr < `FAS_CODE_TOP;
                     rq.op    = FAS_FM_WRITE;
                     rq.ben   = 4'b0001 << sdl_addr[1:0];
                     rq.wdata = {4{sdl_data}};
                  end
                  `FAS_OP_ERASE:
                  begin
                     // serial erase leaves serial safe alone
                     ok              = 1'b1;
                     rq.op           = FAS_FM_ARRAY_ERASE_CMD;
                     rq.addr         = `FAS_CODE_TOP;
                     st_d.sec.lock   = 1'b0;
                     st_d.sec.secure = 1'b0;
                  end
                  `FAS_OP_SEC:
                  begin
                     // security bits are set here by OR, never cleared; only an erase clears them
                     ok       = 1'b1;
                     st_d.sec = st_q.sec | fas_sec_t'(sdl_data[3:0]);
                     rq.op    = FAS_FM_CFG;
                     rq.wdata = {28'h0000000, st_d.sec};
                  end
               endcase
               st_d.sdl_ack = ~ok;
            end
            else if (pp_on && pp_edge)
            begin
               // parallel bus taken on the filtered strobe edge
               rq.code  = 1'b1;
               rq.addr  = pp_addr;
               st_d.src = FAS_SRC_PP;
               unique case (pin_s[4:3])
                  `FAS_OP_READ:
                  begin
                     ok    = ~st_q.sec.secure;
                     rq.op = FAS_FM_READ;
                  end
                  `FAS_OP_PROG:
                  begin
                     ok       = ~st_q.sec.lock & ~st_q.sec.secure
                                & (pp_addr < `FAS_CODE_TOP);
                     rq.op    = FAS_FM_WRITE;
                     rq.ben   = 4'b0001 << pp_addr[1:0];
                     rq.wdata = {4{pp_d_i}};
                  end
                  `FAS_OP_ERASE:
                  begin
                     ok       = 1'b1;
                     rq.op    = FAS_FM_ARRAY_ERASE_CMD;
                     rq.addr  = `FAS_CODE_TOP;
                     st_d.sec = '0;
                  end
                  `FAS_OP_SEC:
                  begin
                     ok       = 1'b1;
                     st_d.sec = st_q.sec | fas_sec_t'(pp_d_i[3:0]);
                     rq.op    = FAS_FM_CFG;
                     rq.wdata = {28'h0000000, st_d.sec};
                  end
               endcase
            end
            if (ok)
            begin
               st_d.fm     = rq;
               st_d.fm.req = 1'b1;
               st_d.state  = FAS_S_BUSY;
            end
         end

         FAS_S_BUSY:
         begin
            // one operation at a time; the macro answers with fm_done
            if (fm_done)
            begin
               st_d.state = FAS_S_IDLE;
               unique case (st_q.src)
                  FAS_SRC_CORE:
                  begin
                     if (st_q.cmd == `FAS_CMD_RDPAGE)
                     begin
                        st_d.page = fm_rdata;
                     end
                     else if (st_q.cmd == `FAS_CMD_RDBYTE)
                     begin
                        st_d.page[0] = rbyte;
                     end
                     else if (st_q.cmd == `FAS_CMD_VERIFY && fm_rdata == st_q.page)
                     begin
                        // a mismatch keeps the nonzero command code
                        st_d.cmd = `FAS_VERIFY_OK;
                     end
                  end
                  FAS_SRC_SDL:
                  begin
                     st_d.sdl_ack   = 1'b1;
                     st_d.sdl_rdata = rbyte;
                  end
                  FAS_SRC_PP:
                  begin
                     if (st_q.fm.op == FAS_FM_READ && pp_on
                         && pin_s[4:3] == `FAS_OP_READ)
                     begin
                        st_d.pp_d  = rbyte;
                        st_d.pp_oe = 1'b1;
                     end
                  end
                  default: ;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         st_q       <= '0;
         st_q.state <= FAS_S_INIT;
         st_q.hold  <= 1'b1;
         st_q.vec   <= `FAS_RST_VEC;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign reg_rdata    = st_q.rdata;
   assign code_int     = st_q.code_int;
   assign code_deny    = st_q.code_deny;
   assign reset_vector = st_q.vec;
   assign core_hold    = st_q.hold;
   assign sdl_mode     = st_q.sdl_mode;
   assign sdl_ack      = st_q.sdl_ack;
   assign sdl_rdata    = st_q.sdl_rdata;
   assign pp_d_o       = st_q.pp_d;
   assign pp_d_oe      = st_q.pp_oe;
   assign fm           = st_q.fm;

endmodule // fas_ctrl

//--- fas_params.svh
// constants of the flash access and security block
// What this block does
// - code array fills lowest 62 kB of space
// - strap low at reset enters serial download
// - parallel ports carry address, data, strobe, operation
// - code array read-only outside user download
// - user download rewrites lower 56 kB only
// - upper 6 kB writable only by programmers
// - bootload option starts execution at E000H
// - lock rejects parallel writes, allows reads
// - secure blocks parallel access, external code reads
// - secure blocks data array from external code
// - code erase by programmers clears lock, secure
// - serial safe turns strap reset into normal
// - only parallel code erase clears serial safe
// - three security bits are independent
// - data array is 1024 four-byte pages
// - four data bytes, address pair select page
// - command register takes nine commands
// - command targets data or user code region
// - read page, write page or code block
// - erase page or whole array or region
// - verify leaves zero on match, else nonzero
// - F0H targets code, 0FH targets data
`ifndef FAS_PARAMS_SVH
`define FAS_PARAMS_SVH

// address map
`define FAS_CODE_TOP   16'hf800
`define FAS_USER_TOP   16'he000
`define FAS_DATA_TOP   16'h1000
`define FAS_BOOT_VEC   16'he000
`define FAS_RST_VEC    16'h0000

// register port offsets
`define FAS_OFS_CMD    3'h0
`define FAS_OFS_BYTE1  3'h1
`define FAS_OFS_BYTE2  3'h2
`define FAS_OFS_BYTE3  3'h3
`define FAS_OFS_BYTE4  3'h4
`define FAS_OFS_ADRL   3'h5
`define FAS_OFS_ADRH   3'h6
`define FAS_OFS_STAT   3'h7

// command codes
`define FAS_CMD_RDPAGE 8'h01
`define FAS_CMD_WRPAGE 8'h02
`define FAS_CMD_VERIFY 8'h04
`define FAS_CMD_ERPAGE 8'h05
`define FAS_CMD_ERALL  8'h06
`define FAS_CMD_RDBYTE 8'h81
`define FAS_CMD_WRBYTE 8'h82
`define FAS_CMD_TODATA 8'h0f
`define FAS_CMD_TOCODE 8'hf0
`define FAS_VERIFY_OK  8'h00

// programmer operations, parallel and serial alike
`define FAS_OP_READ    2'h0
`define FAS_OP_PROG    2'h1
`define FAS_OP_ERASE   2'h2
`define FAS_OP_SEC     2'h3

// reset and start-up
`define FAS_INIT_CYC   2'h3
`define FAS_SYNC_W     5
`define FAS_SYNC_RST   5'h01

`endif

//--- fas_pkg.sv
// types of the flash access and security block
`include "fas_params.svh"
package fas_pkg;

   typedef enum logic [2:0] {
      FAS_S_INIT = 3'b001,
      FAS_S_IDLE = 3'b010,
      FAS_S_BUSY = 3'b100
   } fas_state_t;

   typedef enum logic [2:0] {
      FAS_FM_READ     = 3'h0,
      FAS_FM_WRITE    = 3'h1,
      FAS_FM_WRITE256 = 3'h2,
      FAS_FM_ERASE    = 3'h3,
      FAS_FM_ARRAY_ERASE_CMD = 3'h4,
      FAS_FM_CFG      = 3'h5
   } fas_fm_op_t;

   typedef enum logic [1:0] {
      FAS_SRC_CORE = 2'h0,
      FAS_SRC_SDL  = 2'h1,
      FAS_SRC_PP   = 2'h2
   } fas_src_t;

   typedef struct packed {
      logic lock;
      logic secure;
      logic safe;
      logic boot;
   } fas_sec_t;

   typedef struct packed {
      logic        req;
      fas_fm_op_t  op;
      logic        code;
      logic [15:0] addr;
      logic [3:0]  ben;
      logic [31:0] wdata;
   } fas_fm_req_t;

   typedef struct packed {
      fas_state_t      state;
      fas_src_t        src;
      logic            hold;
      logic [1:0]      init_cnt;
      logic [7:0]      cmd;
      logic [3:0][7:0] page;
      logic [7:0]      adrl;
      logic [7:0]      adrh;
      logic            user_download_mode;
      logic            sdl_mode;
      fas_sec_t        sec;
      logic [15:0]     vec;
      fas_fm_req_t     fm;
      logic [7:0]      rdata;
      logic            code_int;
      logic            code_deny;
      logic            sdl_ack;
      logic [7:0]      sdl_rdata;
      logic [7:0]      pp_d;
      logic            pp_oe;
      logic            strobe;
   } fas_st_t;

   typedef struct packed {
      logic [`FAS_SYNC_W-1:0] a;
      logic [`FAS_SYNC_W-1:0] b;
      logic [`FAS_SYNC_W-1:0] c;
      logic [`FAS_SYNC_W-1:0] o;
   } fas_sync_st_t;

endpackage

//--- fas_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "fas_params.svh"
module fas_sync3
(
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst_b,
   // pins and their clean copies
   input  wire logic [`FAS_SYNC_W-1:0] pin_a,
   output wire logic [`FAS_SYNC_W-1:0] pin_s
);
   import fas_pkg::*;

   fas_sync_st_t st_q;
   fas_sync_st_t st_d;
   logic [`FAS_SYNC_W-1:0] agree;

   // first stage feeds only the second; a bit moves once b and c agree
   always_comb
   begin
      st_d   = st_q;
      agree  = ~(st_q.b ^ st_q.c);
      st_d.a = pin_a;
      st_d.b = st_q.a;
      st_d.c = st_q.b;
      st_d.o = (agree & st_q.c) | (~agree & st_q.o);
   end

   always_ff @(posedge mclk)
   begin
      // stages run on in reset, so a strap held low is settled at release
      st_q <= st_d;
      if (!rst_b)
      begin
         st_q.o <= `FAS_SYNC_RST;
      end
   end

   assign pin_s = st_q.o;

endmodule // fas_sync3

//--- fas_ctrl_assertions.sv
// port checker for the flash access controller
`timescale 1ns/1ps
module fas_ctrl_assertions
(
   // clock and reset
   input wire logic                 mclk,
   input wire logic                 rst_b,
   // register port and core
   input wire logic                 reg_rd,
   input wire logic [7:0]           reg_rdata,
   input wire logic                 cpu_cread,
   input wire logic [15:0]          cpu_caddr,
   input wire logic                 cpu_ext_exec,
   input wire logic                 code_int,
   input wire logic                 code_deny,
   input wire logic [15:0]          reset_vector,
   input wire logic                 core_hold,
   // download and macro
   input wire logic                 download_strap_pin,
   input wire logic                 sdl_mode,
   input wire logic                 sdl_req,
   input wire logic                 sdl_ack,
   input wire fas_pkg::fas_sec_t    nv_sec,
   input wire fas_pkg::fas_fm_req_t fm,
   input wire logic                 fm_done
);
   import fas_pkg::*;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   sequence s_up;
      $fell(core_hold);
   endsequence
   sequence s_start;
      ##[3:6] !core_hold;
   endsequence
   a_code_map:
      assert property (rst_b && $past(rst_b) |-> code_int == ($past(cpu_caddr) < 16'hf800))
      else $error("code_int does not follow the address map");
   a_upper_guard:
      assert property (fm.req && fm.code && fm.op inside {FAS_FM_WRITE, FAS_FM_WRITE256,
         FAS_FM_ERASE} |-> fm.addr < 16'hf800) else $error("write above code array");
   a_deny_cause:
      assert property (code_deny |-> $past(cpu_cread && cpu_ext_exec && cpu_caddr < 16'hf800))
      else $error("code_deny without an external internal read");
   a_hold_bound:
      assert property ($rose(rst_b) |-> s_start) else $error("start-up does not end");
   a_vec_select:
      assert property (s_up |-> reset_vector == (nv_sec.boot ? 16'he000 : 16'h0000))
      else $error("wrong start vector");
   a_dl_entry:
      assert property (s_up |-> sdl_mode == (!download_strap_pin && !nv_sec.safe))
      else $error("wrong download mode at start-up");
   a_rd_quiet:
      assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
   a_req_pulse:
      assert property (fm.req |=> !fm.req) else $error("macro request longer than a cycle");
   a_ack_cause:
      assert property (sdl_ack |-> $past(fm_done || sdl_req)) else $error("ack without cause");
endmodule // fas_ctrl_assertions

//--- fas_flash_model.sv
// behavioural flash array macro with random completion delay
`timescale 1ns/1ps
module fas_flash_model
(
   // clock and request
   input  wire logic                 mclk,
   input  wire fas_pkg::fas_fm_req_t fm,
   // completion
   output logic                      fm_done,
   output logic [31:0]               fm_rdata
);
   import fas_pkg::*;
   logic [31:0] mem[logic [14:0]];
   fas_fm_req_t cur;
   logic [14:0] key;
   logic [31:0] w;
   int          n = -1;
   int          b;
   initial
   begin
      fm_done = 1'b0;
      fm_rdata = 32'h0;
   end
   always @(posedge mclk)
   begin
      fm_done <= 1'b0;
      // stale data toggles so it never passes for a result
      fm_rdata <= ~fm_rdata;
      if (fm.req)
      begin
         cur = fm;
         n = $urandom_range(4);
      end
      else if (n > 0)
         n--;
      else if (n == 0)
      begin
         n = -1;
         key = {cur.code, cur.addr[15:2]};
         w = mem.exists(key) ? mem[key] : 32'hffffffff;
         fm_done <= 1'b1;
         fm_rdata <= w;
         // programming only clears bits, as real cells do
         if (cur.op == FAS_FM_WRITE)
         begin
            for (b = 0; b < 4; b++)
               if (cur.ben[b])
                  w[b*8 +: 8] = w[b*8 +: 8] & cur.wdata[b*8 +: 8];
            mem[key] = w;
         end
         else if (cur.op == FAS_FM_ERASE && cur.code)
            for (b = 0; b < 16; b++)
               mem.delete({1'b1, cur.addr[15:6], 4'(b)});
         else if (cur.op == FAS_FM_ERASE)
            mem.delete(key);
      end
   end
endmodule // fas_flash_model

//--- fas_ctrl_tb.sv
// self-checking bench for the flash access controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module fas_ctrl_tb;
   import fas_pkg::*;
   logic        mclk, rst_b, reg_wr, reg_rd, cpu_cread, cpu_ext_exec, download_strap_pin;
   logic        sdl_req, fm_done, code_int, code_deny, core_hold, sdl_mode, sdl_ack, pend;
   logic        pp_mode, pp_strobe, pp_d_oe;
   logic [1:0]  sdl_op;
   logic [2:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, sdl_data, e, pp_d_o;
   logic [15:0] cpu_caddr, sdl_addr, reset_vector, ca, pp_addr;
   logic [31:0] fm_rdata, r;
   fas_sec_t    nv_sec;
   fas_fm_req_t fm, last;
   logic [7:0]  exp_q[$];
   int          n_mismatch, total_checks, n_req, acks, i, j, k;
   fas_ctrl dut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .cpu_cread, .cpu_caddr, .cpu_ext_exec, .code_int, .code_deny, .reset_vector,
      .core_hold, .download_strap_pin, .sdl_mode, .sdl_req, .sdl_op, .sdl_addr, .sdl_data,
      .sdl_ack, .sdl_rdata(), .pp_mode, .pp_strobe, .pp_cfg(2'h0),
      .pp_addr, .pp_d_i(8'h00), .pp_d_o, .pp_d_oe, .nv_sec, .fm, .fm_done,
      .fm_rdata);
   fas_flash_model mem (.mclk, .fm, .fm_done, .fm_rdata);
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(negedge mclk)
   begin
      if (pend)
      begin
         e = exp_q.pop_front();
         `CHK("reg_rdata", e, reg_rdata)
      end
      pend = reg_rd;
      if (fm.req)
      begin
         n_req++;
         last = fm;
      end
      if (sdl_ack)
         acks++;
   end
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] x);
      exp_q.push_back(x);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
   endtask
   task automatic cmd(input logic [7:0] c);
      wr(3'h0, c);
      for (k = 0; k < 20 && fm_done !== 1'b1; k++)
         @(posedge mclk);
      repeat (3) @(posedge mclk);
   endtask
   task automatic boot(input fas_sec_t s, input logic st);
      nv_sec <= s;
      download_strap_pin <= st;
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (6) @(posedge mclk);
      `CHK("reset_vector", s.boot ? 16'he000 : 16'h0000, reset_vector)
      `CHK("sdl_mode", !st && !s.safe, sdl_mode)
   endtask
   task automatic sdl(input logic [15:0] a);
      j = acks;
      i = n_req;
      @(posedge mclk);
      sdl_req <= 1'b1;
      sdl_op <= 2'h1;
      sdl_addr <= a;
      sdl_data <= 8'($urandom);
      @(posedge mclk);
      sdl_req <= 1'b0;
      for (k = 0; k < 20 && sdl_ack !== 1'b1; k++)
         @(posedge mclk);
      repeat (2) @(posedge mclk);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      {rst_b, reg_wr, reg_rd, cpu_cread, cpu_ext_exec, sdl_req, pend, pp_mode, pp_strobe} = '0;
      {reg_addr, reg_wdata, cpu_caddr, sdl_op, sdl_addr, sdl_data, pp_addr} = '0;
      download_strap_pin = 1'b1;
      nv_sec = '0;
      k = $urandom(32'hfe5d);
      boot(4'b0001, 1'b1);
      rd(3'h7, 8'h40);
      r = $urandom;
      wr(3'h5, 8'h03);
      wr(3'h6, 8'h00);
      for (i = 0; i < 4; i++)
         wr(3'(i + 1), r[i*8 +: 8]);
      cmd(8'h02);
      for (i = 1; i < 5; i++)
         wr(3'(i), 8'h00);
      cmd(8'h01);
      for (i = 0; i < 4; i++)
         rd(3'(i + 1), r[i*8 +: 8]);
      cmd(8'h04);
      rd(3'h0, 8'h00);
      wr(3'h1, ~r[7:0]);
      cmd(8'h04);
      rd(3'h0, 8'h04);
      j = n_req;
      cmd(8'h03);
      rd(3'h0, 8'h04);
      `CHK("req_count", j, n_req)
      cmd(8'h05);
      cmd(8'h01);
      rd(3'h4, 8'hff);
      cmd(8'hf0);
      rd(3'h7, 8'h42);
      j = n_req;
      wr(3'h6, 8'he0);
      cmd(8'h05);
      `CHK("req_count", j, n_req)
      wr(3'h6, 8'h10);
      cmd(8'h05);
      `CHK("code_sel", 1'b1, last.code)
      `CHK("code_addr", 16'h1000, last.addr)
      cmd(8'h0f);
      rd(3'h7, 8'h40);
      cmd(8'h05);
      `CHK("code_sel", 1'b0, last.code)
      boot(4'b0100, 1'b1);
      cpu_ext_exec <= 1'b1;
      j = n_req;
      cmd(8'h01);
      `CHK("req_count", j, n_req)
      for (i = 0; i < 8; i++)
      begin
         ca = {i[0] ? 5'h1f : 5'($urandom_range(30)), 11'($urandom)};
         @(posedge mclk);
         cpu_caddr <= ca;
         cpu_cread <= 1'b1;
         repeat (2) @(posedge mclk);
         `CHK("code_int", ca < 16'hf800, code_int)
         `CHK("code_deny", ca < 16'hf800, code_deny)
      end
      cpu_cread <= 1'b0;
      cpu_ext_exec <= 1'b0;
      boot(4'b0000, 1'b0);
      sdl(16'hf800);
      `CHK("sdl_ack", j + 1, acks)
      `CHK("req_count", i, n_req)
      sdl(16'h0102);
      `CHK("sdl_lane", 4'b0100, last.ben)
      {pp_mode, pp_strobe} <= 2'b11;
      pp_addr <= 16'h0102;
      repeat (14) @(posedge mclk);
      `CHK("pp_read", {1'b1, sdl_data}, {pp_d_oe, pp_d_o})
      {pp_mode, pp_strobe} <= 2'b00;
      boot(4'b0010, 1'b0);
      sdl(16'h0102);
      `CHK("sdl_ack", j, acks)
      give_verdict;
   end
   initial
   begin
      #40000;
      n_mismatch++;
      give_verdict;
   end
endmodule // fas_ctrl_tb
bind fas_ctrl fas_ctrl_assertions chk (.mclk, .rst_b, .reg_rd, .reg_rdata, .cpu_cread,
   .cpu_caddr, .cpu_ext_exec, .code_int, .code_deny, .reset_vector, .core_hold,
   .download_strap_pin, .sdl_mode, .sdl_req, .sdl_ack, .nv_sec, .fm, .fm_done);
